//--- logic/dsl_serial_port.sv
// Serial load port of a dual DAC: shifter, decoder, DAC registers, readback.
module dsl_serial_port (
  input  wire logic                 ref_clk,           // System clock, 50 MHz.
  input  wire logic                 rst,               // Synchronous reset, active high.
  input  wire logic                 sclk_pin,          // Serial shift clock level.
  input  wire logic                 frame_n_pin,       // Frame select, active low.
  input  wire logic                 serial_in_pin,     // Serial data in.
  input  wire logic                 dac_load_strobe_n, // Load strobe, active low.
  input  wire logic                 clear_input_n,     // Clear, active low.
  input  wire logic                 core_ready,        // Converter core accepts words.
  output logic                      serial_out_pin,    // Serial data out.
  output logic [dsl_pkg::CODE_W-1:0] dac_a_code,       // DAC A register.
  output logic [dsl_pkg::CODE_W-1:0] dac_b_code,       // DAC B register.
  output logic                      edge_rising,       // Active edge is rising.
  output logic                      daisy_mode         // Daisy-chain mode selected.
);
  import dsl_pkg::*;

  logic              sclk_prev_reg, frame_prev_reg, dac_load_strobe_n_prev_reg;
  logic              rising_reg, daisy_reg, midscale_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic              chain_bit_reg;
  logic              pend_valid_reg;
  logic [WORD_W-1:0] pend_word_reg;
  logic [CODE_W-1:0] input_a_reg, input_b_reg, dac_a_reg, dac_b_reg;
  logic [WORD_W-1:0] rb_shift_reg;
  logic [CNT_W-1:0]  rb_cnt_reg;
  logic              out_reg;

  dsl_word_if #(.W(WORD_W)) fill_if ();
  dsl_word_if #(.W(WORD_W)) drain_if ();

  dsl_word_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr      (fill_if),
    .rd      (drain_if)
  );

  // Edge detection on the clock, frame and strobe levels.
  wire sclk_rise    = sclk_pin && !sclk_prev_reg;
  wire sclk_fall    = !sclk_pin && sclk_prev_reg;
  wire active_edge  = rising_reg ? sclk_rise : sclk_fall;        // RQ4 RQ5
  wire opp_edge     = rising_reg ? sclk_fall : sclk_rise;        // RQ7
  wire in_frame     = !frame_n_pin;                              // RQ11
  wire frame_end    = frame_n_pin && !frame_prev_reg;
  wire dac_load_strobe_n_fall    = !dac_load_strobe_n && dac_load_strobe_n_prev_reg;
  wire clearing     = !clear_input_n;
  wire shift_now    = in_frame && active_edge && !clearing;      // RQ6
  wire last_bit     = (bit_cnt_reg == LAST_BIT);
  wire sa_latch     = !daisy_reg && shift_now && last_bit;       // RQ12 RQ2
  wire dc_latch     = daisy_reg && frame_end && !clearing;       // RQ3
  wire latch_now    = sa_latch || dc_latch;
  wire [WORD_W-1:0] shifted    = {shift_reg[WORD_W-2:0], serial_in_pin};
  wire [WORD_W-1:0] latch_word = sa_latch ? shifted : shift_reg;
  wire [CODE_W-1:0] clear_code = midscale_reg ? MID_CODE : ZERO_CODE;

  // Decoding of the word leaving the buffer.
  wire              pop      = drain_if.valid && drain_if.ready;
  wire [3:0]        cmd      = drain_if.data[CMD_MSB:CMD_LSB];
  wire [CODE_W-1:0] code     = drain_if.data[CODE_W-1:0];
  wire              ld_a     = pop && cmd == CMD_LOAD_A;
  wire              ld_b     = pop && cmd == CMD_LOAD_B;
  wire              rd_a     = pop && cmd == CMD_READ_A;        // RQ9
  wire              rd_b     = pop && cmd == CMD_READ_B;        // RQ9
  wire              cfg_wr   = pop && cmd == CMD_CONFIG;
  wire              auto_upd = !dac_load_strobe_n;              // RQ2 RQ3
  wire [CODE_W-1:0] in_a_next  = clearing ? clear_code : (ld_a ? code : input_a_reg);
  wire [CODE_W-1:0] in_b_next  = clearing ? clear_code : (ld_b ? code : input_b_reg);
  // A strobe edge moves the held inputs; a held-low strobe moves fresh loads.
  wire [CODE_W-1:0] dac_a_next = clearing ? clear_code :
                                 (ld_a && auto_upd) ? code :
                                 dac_load_strobe_n_fall ? input_a_reg : dac_a_reg;      // RQ1
  wire [CODE_W-1:0] dac_b_next = clearing ? clear_code :
                                 (ld_b && auto_upd) ? code :
                                 dac_load_strobe_n_fall ? input_b_reg : dac_b_reg;      // RQ1
  wire [WORD_W-1:0] rb_word    = {{(WORD_W-CODE_W){1'b0}}, rd_a ? dac_a_reg : dac_b_reg};

  assign drain_if.ready = core_ready;
  assign fill_if.valid  = pend_valid_reg;
  assign fill_if.data   = pend_word_reg;

  assign serial_out_pin = out_reg;
  assign dac_a_code     = dac_a_reg;
  assign dac_b_code     = dac_b_reg;
  assign edge_rising    = rising_reg;
  assign daisy_mode     = daisy_reg;

  // Previous levels for edge detection. The strobe history starts low, so a strobe held low
  // through reset gives no false load edge on the first cycle after release.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev_reg  <= 1'b0;
      frame_prev_reg <= 1'b1;
      dac_load_strobe_n_prev_reg  <= 1'b0;
    end else begin
      sclk_prev_reg  <= sclk_pin;
      frame_prev_reg <= frame_n_pin;
      dac_load_strobe_n_prev_reg  <= dac_load_strobe_n;
    end
  end

  // Input shifter and bit counter; an idle frame holds the count at zero.
  always_ff @(posedge ref_clk) begin
    if (rst || clearing) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (!in_frame) begin
      bit_cnt_reg <= '0;                                          // RQ11
    end else if (shift_now) begin
      shift_reg   <= shifted;                                     // RQ6
      bit_cnt_reg <= last_bit ? '0 : bit_cnt_reg + 1'b1;          // RQ12
    end
  end

  // Chain bit follows the top of the shifter after each shift. A cascaded device then sees
  // each word exactly sixteen active edges later, not seventeen.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chain_bit_reg <= 1'b0;
    end else if (shift_now) begin
      chain_bit_reg <= shifted[WORD_W-1];                         // RQ8
    end
  end

  // Pending word waits here while the buffer is full, so the shifter stalls no data.
  // A new word arriving in the same cycle as acceptance wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_valid_reg <= 1'b0;
      pend_word_reg  <= '0;
    end else if (latch_now) begin
      pend_valid_reg <= 1'b1;
      pend_word_reg  <= latch_word;
    end else if (fill_if.ready) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // Configuration word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rising_reg   <= RST_RISING;                                 // RQ4
      daisy_reg    <= RST_DAISY;
      midscale_reg <= RST_MIDSCALE;
    end else if (cfg_wr) begin
      rising_reg   <= drain_if.data[CFG_RISING];                  // RQ5
      daisy_reg    <= drain_if.data[CFG_DAISY];
      midscale_reg <= drain_if.data[CFG_MIDSCALE];                // RQ13
    end
  end

  // Input and DAC registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_a_reg <= ZERO_CODE;
      input_b_reg <= ZERO_CODE;
      dac_a_reg   <= ZERO_CODE;
      dac_b_reg   <= ZERO_CODE;
    end else begin
      input_a_reg <= in_a_next;                                   // RQ13
      input_b_reg <= in_b_next;
      dac_a_reg   <= dac_a_next;
      dac_b_reg   <= dac_b_next;
    end
  end

  // Serial output: readback bits take priority over pass-through chain data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rb_shift_reg <= '0;
      rb_cnt_reg   <= '0;
      out_reg      <= 1'b0;
    end else if (rd_a || rd_b) begin
      rb_shift_reg <= rb_word;                                    // RQ9
      rb_cnt_reg   <= RB_BITS;                                    // RQ10
    end else if (opp_edge) begin
      if (rb_cnt_reg != '0) begin
        out_reg      <= rb_shift_reg[WORD_W-1];                   // RQ10
        rb_shift_reg <= {rb_shift_reg[WORD_W-2:0], 1'b0};
        rb_cnt_reg   <= rb_cnt_reg - 1'b1;
      end else begin
        out_reg      <= chain_bit_reg;                            // RQ7 RQ8
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_strobe_edge_load: assert property (dac_load_strobe_n_fall && !clearing && !pop
      |=> dac_a_code == $past(input_a_reg) && dac_b_code == $past(input_b_reg)) // RQ1
    else $error("Strobe edge did not move inputs to DAC registers.");
  chk_standalone_latch: assert property (sa_latch |=> pend_valid_reg
      && pend_word_reg == $past(shifted)) // RQ2 RQ12
    else $error("Sixteenth edge did not latch the word.");
  chk_daisy_frame_end: assert property (dc_latch |=> pend_valid_reg
      && pend_word_reg == $past(shift_reg)) // RQ3
    else $error("Frame end in daisy mode did not latch the word.");
  chk_auto_update: assert property (ld_a && auto_upd && !clearing
      |=> dac_a_code == $past(code)) // RQ2 RQ3
    else $error("Held-low strobe did not update the DAC.");
  chk_default_edge: assert property ($fell(rst) |-> !edge_rising) // RQ4
    else $error("Active edge is not falling after reset.");
  chk_edge_select: assert property (cfg_wr |=> edge_rising == $past(drain_if.data[CFG_RISING])) // RQ5
    else $error("Configuration word did not set the active edge.");
  chk_shift_bit: assert property (shift_now |=> shift_reg[0] == $past(serial_in_pin)
      && shift_reg[WORD_W-1:1] == $past(shift_reg[WORD_W-2:0])) // RQ6
    else $error("Active edge did not shift one bit.");
  chk_out_edge: assert property ($changed(serial_out_pin) |-> $past(opp_edge)) // RQ7
    else $error("Serial output changed off the opposite edge.");
  chk_chain_pass: assert property (opp_edge && rb_cnt_reg == '0 && !rd_a && !rd_b
      |=> serial_out_pin == $past(chain_bit_reg)) // RQ8
    else $error("Chain bit not passed to the serial output.");
  chk_readback_len: assert property (rd_a |=> rb_cnt_reg == RB_BITS
      && rb_shift_reg[CODE_W-1:0] == $past(dac_a_reg)) // RQ9 RQ10
    else $error("Readback did not load sixteen bits of the DAC register.");
  chk_idle_frame: assert property (frame_n_pin |=> bit_cnt_reg == '0) // RQ11
    else $error("Bit count moved outside a frame.");
  chk_clear_regs: assert property (clearing |=> dac_a_code == $past(clear_code)
      && input_b_reg == $past(clear_code)) // RQ13
    else $error("Clear did not load the clear code.");
endmodule : dsl_serial_port

//--- pkg/dsl_pkg.sv
// Constants shared by the serial load port of the dual DAC.
// Notes on behaviour
// RQ1: Load strobe falling edge updates DAC registers immediately.
// RQ2: Strobe held low, standalone: update on 16th edge.
// RQ3: Strobe held low, daisy-chain: update at frame end.
// RQ4: After reset, sample input on falling clock edges.
// RQ5: Control word may select rising edge as active.
// RQ6: Words are 16 bits, one bit per active edge.
// RQ7: Serial output changes on the opposite clock edge.
// RQ8: Shifted data passes out for cascading devices.
// RQ9: Readback word puts DAC register on serial output.
// RQ10: Readback bits leave on next 16 opposite edges.
// RQ11: Frame select low enables shifting; high idles.
// RQ12: Standalone mode latches word on 16th active edge.
// RQ13: Clear input resets registers to zero or midscale.
package dsl_pkg;
  localparam int         WORD_W       = 16;
  localparam int         CODE_W       = 12;
  localparam int         CNT_W        = 5;
  localparam int         BUF_DEPTH    = 2;
  // Command field sits in the top nibble of each word.
  localparam int         CMD_MSB      = 15;
  localparam int         CMD_LSB      = 12;
  localparam logic [3:0] CMD_LOAD_A   = 4'h1;
  localparam logic [3:0] CMD_LOAD_B   = 4'h2;
  localparam logic [3:0] CMD_READ_A   = 4'h3;
  localparam logic [3:0] CMD_READ_B   = 4'h4;
  localparam logic [3:0] CMD_CONFIG   = 4'hd;
  // Configuration word bit positions.
  localparam int         CFG_RISING   = 0;
  localparam int         CFG_DAISY    = 1;
  localparam int         CFG_MIDSCALE = 2;
  // Reset values, clear codes, last bit index and readback length.
  localparam logic       RST_RISING   = 1'b0;
  localparam logic       RST_DAISY    = 1'b0;
  localparam logic       RST_MIDSCALE = 1'b0;
  localparam logic [11:0] ZERO_CODE   = 12'h000;
  localparam logic [11:0] MID_CODE    = 12'h800;
  localparam logic [4:0] LAST_BIT     = 5'h0f;
  localparam logic [4:0] RB_BITS      = 5'h10;
endpackage : dsl_pkg

//--- pkg/dsl_word_if.sv
// Valid and ready word channel between the port's own modules.
interface dsl_word_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dsl_word_if

//--- logic/dsl_word_buffer.sv
// Small word buffer with valid and ready on both sides.
module dsl_word_buffer #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk, // System clock.
  input wire logic rst,     // Synchronous reset, active high.
  dsl_word_if.snk  wr,      // Filling side.
  dsl_word_if.src  rd       // Draining side.
);
  import dsl_pkg::*;

  if (DEPTH != 2) begin : g_bad_depth
    $error("dsl_word_buffer supports a depth of two only.");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;
  wire          push = wr.valid && wr.ready;
  wire          pop  = rd.valid && rd.ready;

  // Ready comes from the count register so a stalled drain holds off the filler.
  assign wr.ready = (count_reg != 2'(DEPTH));
  assign rd.valid = (count_reg != 2'h0);
  assign rd.data  = mem_reg[rd_ptr_reg];

  // One storage slot per entry; only the addressed slot loads.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk) begin
      if (push && wr_ptr_reg == 1'(i)) begin
        mem_reg[i] <= wr.data;
      end
    end
  end

  // Pointers and fill count.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg  <= count_reg + 2'(push) - 2'(pop);
    end
  end
endmodule : dsl_word_buffer

//--- bench/dsl_host_model.sv
// Host serial port model that frames words and collects the serial output.
module dsl_host_model (
  input  wire logic ref_clk,        // System clock.
  input  wire logic serial_out_pin, // Serial data from the port.
  output logic      sclk_pin,       // Shift clock.
  output logic      frame_n_pin,    // Frame select, active low.
  output logic      serial_in_pin   // Serial data to the port.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The shift clock idles low so the port never sees a stray edge at reset release.
  initial begin
    sclk_pin      = 1'b0;
    frame_n_pin   = 1'b1;
    serial_in_pin = 1'b0;
  end

  // Waits a number of falling system clock edges.
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hold

  // Sends n bits MSB first; each clock level lasts two cycles so every edge is seen.
  task automatic xfer(input logic [31:0] w, input int n, input logic rise,
                      output logic [31:0] rx);
    rx = '0;
    @(negedge ref_clk);
    frame_n_pin = 1'b0;
    hold(2);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_pin      = ~rise;
      serial_in_pin = w[i];
      hold(2);
      rx       = {rx[30:0], serial_out_pin};
      sclk_pin = rise;
      hold(2);
    end
    frame_n_pin   = 1'b1;
    serial_in_pin = ~serial_in_pin; // A released line must not keep its last bit.
    hold(2);
    sclk_pin = 1'b0;
    hold(4);
  endtask : xfer
endmodule : dsl_host_model

//--- bench/dsl_serial_port_tb_top.sv
// Self-checking testbench of the serial load port with a host model.
module dsl_serial_port_tb_top;
  import dsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk, rst, sclk_pin, frame_n_pin, serial_in_pin, serial_out_pin;
  logic              dac_load_strobe_n, clear_input_n, core_ready, edge_rising, daisy_mode;
  logic [CODE_W-1:0] dac_a_code, dac_b_code;
  logic [31:0]       rx;
  int                num_errors, checked;

  dsl_serial_port dut_u (
    .ref_clk(ref_clk), .rst(rst), .sclk_pin(sclk_pin), .frame_n_pin(frame_n_pin),
    .serial_in_pin(serial_in_pin), .dac_load_strobe_n(dac_load_strobe_n),
    .clear_input_n(clear_input_n), .core_ready(core_ready),
    .serial_out_pin(serial_out_pin), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
    .edge_rising(edge_rising), .daisy_mode(daisy_mode));

  dsl_host_model host_u (
    .ref_clk(ref_clk), .serial_out_pin(serial_out_pin), .sclk_pin(sclk_pin),
    .frame_n_pin(frame_n_pin), .serial_in_pin(serial_in_pin));

  // The 50 MHz system clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Sends one 16-bit word and leaves time for the decode pipeline.
  task automatic send(input logic [15:0] w, input logic rise);
    host_u.xfer({16'h0000, w}, 16, rise, rx);
    host_u.hold(4);
  endtask : send

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Outputs after reset show a zero DAC A code, falling edge and standalone mode.
  task automatic t_reset();
    chk("dac_a", 32'(ZERO_CODE), 32'(dac_a_code));
    chk("edge_rising", 32'h0, 32'(edge_rising));
    chk("daisy_mode", 32'h0, 32'(daisy_mode));
    $display("test reset done");
  endtask : t_reset

  // Strobe held low in standalone mode loads on the sixteenth active edge.
  task automatic t_auto();
    send({CMD_LOAD_A, 12'habc}, 1'b0);
    chk("dac_a", 32'h0abc, 32'(dac_a_code));
    send({CMD_LOAD_B, 12'h123}, 1'b0);
    chk("dac_b", 32'h0123, 32'(dac_b_code));
    $display("test auto load done");
  endtask : t_auto

  // A high strobe holds the DAC register until its falling edge.
  task automatic t_strobe();
    dac_load_strobe_n = 1'b1;
    send({CMD_LOAD_A, 12'h555}, 1'b0);
    chk("dac_a held", 32'h0abc, 32'(dac_a_code));
    dac_load_strobe_n = 1'b0;
    host_u.hold(2);
    chk("dac_a strobed", 32'h0555, 32'(dac_a_code));
    $display("test strobe done");
  endtask : t_strobe

  // A read word makes the next frame carry the DAC A code on the serial output.
  task automatic t_readback();
    send({CMD_READ_A, 12'h000}, 1'b0);
    send(16'h0000, 1'b0);
    chk("readback", 32'h0555, {16'h0000, rx[15:0]});
    $display("test readback done");
  endtask : t_readback

  // Daisy mode passes the first word on and loads only when the frame closes.
  task automatic t_daisy();
    send({CMD_CONFIG, 12'h002}, 1'b0);
    chk("daisy_mode", 32'h1, 32'(daisy_mode));
    host_u.xfer({CMD_LOAD_B, 12'h777, CMD_LOAD_A, 12'h333}, 32, 1'b0, rx);
    host_u.hold(4);
    chk("chain out", {16'h0000, CMD_LOAD_B, 12'h777}, {16'h0000, rx[15:0]});
    chk("dac_a", 32'h0333, 32'(dac_a_code));
    chk("dac_b", 32'h0123, 32'(dac_b_code));
    $display("test daisy done");
  endtask : t_daisy

  // Rising active edge, then clear to midscale, then words queued behind a stalled core.
  task automatic t_rise_clear_buf();
    send({CMD_CONFIG, 12'h001}, 1'b0);
    chk("edge_rising", 32'h1, 32'(edge_rising));
    send({CMD_LOAD_A, 12'h246}, 1'b1);
    chk("dac_a rising", 32'h0246, 32'(dac_a_code));
    send({CMD_CONFIG, 12'h005}, 1'b1);
    clear_input_n = 1'b0;
    host_u.hold(3);
    chk("dac_a clear", 32'(MID_CODE), 32'(dac_a_code));
    chk("dac_b clear", 32'(MID_CODE), 32'(dac_b_code));
    clear_input_n = 1'b1;
    core_ready    = 1'b0;
    send({CMD_LOAD_A, 12'h111}, 1'b1);
    send({CMD_LOAD_B, 12'h222}, 1'b1);
    send({CMD_LOAD_A, 12'h333}, 1'b1);
    chk("dac_a stalled", 32'(MID_CODE), 32'(dac_a_code));
    core_ready = 1'b1;
    host_u.hold(8);
    chk("dac_a drained", 32'h0333, 32'(dac_a_code));
    chk("dac_b drained", 32'h0222, 32'(dac_b_code));
    $display("test rise clear buffer done");
  endtask : t_rise_clear_buf

  // Mid-run reset restores defaults; then DAC B readback and a clear to zero scale.
  task automatic t_rst_readb();
    rst = 1'b1;
    host_u.hold(3);
    rst = 1'b0;
    host_u.hold(2);
    chk("dac_a after reset", 32'(ZERO_CODE), 32'(dac_a_code));
    chk("edge_rising after reset", 32'h0, 32'(edge_rising));
    chk("serial_out after reset", 32'h0, 32'(serial_out_pin));
    send({CMD_LOAD_B, 12'h9a5}, 1'b0);
    chk("dac_b", 32'h09a5, 32'(dac_b_code));
    send({CMD_READ_B, 12'h000}, 1'b0);
    send(16'h0000, 1'b0);
    chk("readback b", 32'h09a5, {16'h0000, rx[15:0]});
    clear_input_n = 1'b0;
    host_u.hold(2);
    chk("dac_b zero clear", 32'(ZERO_CODE), 32'(dac_b_code));
    clear_input_n = 1'b1;
    $display("test reset readback b done");
  endtask : t_rst_readb

  // A hang is cut short well beyond the roughly 1330 cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end

  // Reset for ten cycles, then the scenarios in order.
  initial begin
    rst               = 1'b1;
    dac_load_strobe_n = 1'b0;
    clear_input_n     = 1'b1;
    core_ready        = 1'b1;
    num_errors        = 0;
    checked           = 0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    host_u.hold(2);
    t_reset();
    t_auto();
    t_strobe();
    t_readback();
    t_daisy();
    t_rise_clear_buf();
    t_rst_readb();
    close_out();
  end
endmodule : dsl_serial_port_tb_top
